// *** core/tptg_core.sv ***
/*
  Timing generator for a 9/12-bit active-matrix panel: register port on the
  system clock, line/frame counters and panel strobes on the pixel clock.
  Assumes the pixel clock runs during reset and that the pixel source offers
  a new word on every cycle in which pixel_take is high.
*/
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module tptg_core (
  // System clock and reset.
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  // Register port.
  input  wire logic [tptg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [tptg_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [tptg_pkg::DATA_W-1:0] reg_rdata,
  // Pixel clock and pixel source.
  input  wire logic                        pix_clk,
  input  wire logic [tptg_pkg::PIX_W-1:0]  pixel_data_in,
  output logic                             pixel_take,
  // Panel pins.
  output logic                             frame_pulse_out,
  output logic                             line_pulse_out,
  output logic                             shift_clock_out,
  output logic                             display_enable_strobe,
  output logic      [tptg_pkg::PIX_W-1:0]  panel_pixel_bus
);
  import tptg_pkg::*;

  // ==========================================================================
  // System domain: registers and configuration hand-off.
  logic [7:0]       mode_reg,    mode_next;
  logic [6:0]       hwidth_reg,  hwidth_next;
  logic [9:0]       vlines_reg,  vlines_next;
  logic [4:0]       lpstart_reg, lpstart_next;
  logic [4:0]       hblank_reg,  hblank_next;
  logic [5:0]       fpstart_reg, fpstart_next;
  logic [5:0]       vblank_reg,  vblank_next;
  logic [7:0]       rdata_reg,   rdata_next;
  logic             dirty_reg,   dirty_next;
  logic             req_reg,     req_next;
  logic [CFG_W-1:0] xfer_reg,    xfer_next;
  logic             ack_s1_reg;
  logic             ack_s2_reg;
  logic             vb_s1_reg;
  logic             vb_s2_reg;
  logic             busy;
  logic             mapped_wr;
  logic             ack_tog_reg, ack_tog_next;
  logic             vb_reg,      vb_next;
  logic             panel_on;

  assign busy      = req_reg != ack_s2_reg;
  assign reg_rdata = rdata_reg;

  always_comb begin
    mode_next    = mode_reg;
    hwidth_next  = hwidth_reg;
    vlines_next  = vlines_reg;
    lpstart_next = lpstart_reg;
    hblank_next  = hblank_reg;
    fpstart_next = fpstart_reg;
    vblank_next  = vblank_reg;
    rdata_next   = RST_REG;
    dirty_next   = dirty_reg;
    req_next     = req_reg;
    xfer_next    = xfer_reg;
    mapped_wr    = 1'b0;
    if (reg_wr) begin
      mapped_wr = 1'b1;
      case (reg_addr)
        OFS_MODE:      mode_next         = reg_wdata;
        OFS_HWIDTH:    hwidth_next       = reg_wdata[6:0];
        OFS_VLINES_LO: vlines_next[7:0]  = reg_wdata;
        OFS_VLINES_HI: vlines_next[9:8]  = reg_wdata[1:0];
        OFS_LPSTART:   lpstart_next      = reg_wdata[4:0];
        OFS_HBLANK:    hblank_next       = reg_wdata[4:0];
        OFS_FPSTART:   fpstart_next      = reg_wdata[5:0];
        OFS_VBLANK:    vblank_next       = reg_wdata[5:0];
        default:       mapped_wr         = 1'b0;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_MODE:      rdata_next = mode_reg;
        OFS_HWIDTH:    rdata_next = {1'b0, hwidth_reg};
        OFS_VLINES_LO: rdata_next = vlines_reg[7:0];
        OFS_VLINES_HI: rdata_next = {6'h00, vlines_reg[9:8]};
        OFS_LPSTART:   rdata_next = {3'h0, lpstart_reg};
        OFS_HBLANK:    rdata_next = {3'h0, hblank_reg};
        OFS_FPSTART:   rdata_next = {2'h0, fpstart_reg};
        OFS_VBLANK:    rdata_next = {2'h0, vblank_reg};
        OFS_STATUS: begin
          rdata_next                  = RST_REG;
          rdata_next[STAT_VBLANK_BIT] = vb_s2_reg;
          rdata_next[STAT_BUSY_BIT]   = busy | dirty_reg;
        end
        default:       rdata_next = RST_REG;
      endcase
    end
    // A snapshot is sent only when the previous one has been acknowledged.
    if (dirty_reg && !busy) begin
      xfer_next  = {mode_reg, hwidth_reg, vlines_reg, lpstart_reg,
                    hblank_reg, fpstart_reg, vblank_reg};
      req_next   = ~req_reg;
      dirty_next = 1'b0;
    end
    if (mapped_wr) begin
      dirty_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_reg    <= RST_REG;
      hwidth_reg  <= RST_REG[6:0];
      vlines_reg  <= {RST_REG[1:0], RST_REG};
      lpstart_reg <= RST_REG[4:0];
      hblank_reg  <= RST_REG[4:0];
      fpstart_reg <= RST_REG[5:0];
      vblank_reg  <= RST_REG[5:0];
      rdata_reg   <= RST_REG;
      dirty_reg   <= 1'b0;
      req_reg     <= 1'b0;
      xfer_reg    <= RST_CFG;
      ack_s1_reg  <= 1'b0;
      ack_s2_reg  <= 1'b0;
      vb_s1_reg   <= 1'b0;
      vb_s2_reg   <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      hwidth_reg  <= hwidth_next;
      vlines_reg  <= vlines_next;
      lpstart_reg <= lpstart_next;
      hblank_reg  <= hblank_next;
      fpstart_reg <= fpstart_next;
      vblank_reg  <= vblank_next;
      rdata_reg   <= rdata_next;
      dirty_reg   <= dirty_next;
      req_reg     <= req_next;
      xfer_reg    <= xfer_next;
      ack_s1_reg  <= ack_tog_reg;
      ack_s2_reg  <= ack_s1_reg;
      vb_s1_reg   <= vb_reg;
      vb_s2_reg   <= vb_s1_reg;
    end
  end

  // ==========================================================================
  // Pixel domain: reset synchroniser and configuration capture.
  logic             rst_s1_reg;
  logic             rst_s2_reg;
  logic             req_s1_reg;
  logic             req_s2_reg;
  logic             pend_reg,    pend_next;
  logic [CFG_W-1:0] pend_cfg_reg, pend_cfg_next;
  logic [CFG_W-1:0] cfg_reg,     cfg_next;
  logic             pix_rst_n;
  logic             frame_wrap;

  assign pix_rst_n = rst_s2_reg;

  always_ff @(posedge pix_clk) begin
    rst_s1_reg <= rstn;
    rst_s2_reg <= rst_s1_reg;
  end

  always_comb begin
    ack_tog_next  = ack_tog_reg;
    pend_next     = pend_reg;
    pend_cfg_next = pend_cfg_reg;
    cfg_next      = cfg_reg;
    // New timing takes effect at a frame boundary, or at once while idle.
    if (pend_reg && (frame_wrap || !panel_on)) begin
      cfg_next  = pend_cfg_reg;
      pend_next = 1'b0;
    end
    if (req_s2_reg != ack_tog_reg) begin
      pend_cfg_next = xfer_reg;
      pend_next     = 1'b1;
      ack_tog_next  = ~ack_tog_reg;
    end
  end

  always_ff @(posedge pix_clk) begin
    if (!pix_rst_n) begin
      req_s1_reg   <= 1'b0;
      req_s2_reg   <= 1'b0;
      ack_tog_reg  <= 1'b0;
      pend_reg     <= 1'b0;
      pend_cfg_reg <= RST_CFG;
      cfg_reg      <= RST_CFG;
    end else begin
      req_s1_reg   <= req_reg;
      req_s2_reg   <= req_s1_reg;
      ack_tog_reg  <= ack_tog_next;
      pend_reg     <= pend_next;
      pend_cfg_reg <= pend_cfg_next;
      cfg_reg      <= cfg_next;
    end
  end

  // ==========================================================================
  // Pixel domain: spans derived from the active configuration.
  logic           lpol;
  logic           fpol;
  logic [6:0]     cfg_hw;
  logic [9:0]     cfg_vl;
  logic [4:0]     cfg_lps;
  logic [4:0]     cfg_hnd;
  logic [5:0]     cfg_fps;
  logic [5:0]     cfg_vnd;
  logic [4:0]     lps_eff;
  logic [5:0]     vert_blank_part_one;
  logic [H_W-1:0] horiz_active_span;
  logic [H_W-1:0] horiz_blank_part_one;
  logic [H_W-1:0] horiz_blank_part_two;
  logic [H_W-1:0] line_len;
  logic [V_W-1:0] vert_active_span;
  logic [V_W-1:0] frame_len;
  logic [V_W-1:0] fp_line;

  assign {cfg_hw, cfg_vl, cfg_lps, cfg_hnd, cfg_fps, cfg_vnd} = cfg_reg[CFG_W-9:0];
  assign panel_on = cfg_reg[CFG_W-8+MODE_PANEL_BIT];
  assign lpol     = cfg_reg[CFG_W-8+MODE_LPOL_BIT];
  assign fpol     = cfg_reg[CFG_W-8+MODE_FPOL_BIT];
  // A start field beyond its blank field is clamped so part two never goes negative.
  assign lps_eff  = (cfg_lps > cfg_hnd) ? cfg_hnd : cfg_lps;
  assign vert_blank_part_one    = (cfg_fps > cfg_vnd) ? cfg_vnd : cfg_fps;
  assign horiz_active_span      = (H_W'(cfg_hw) + H_W'(1)) << H_UNIT_SHIFT;
  assign horiz_blank_part_one    = (H_W'(lps_eff) << H_UNIT_SHIFT) + H_BLANK_EXTRA;
  assign horiz_blank_part_two    = (H_W'(cfg_hnd - lps_eff) << H_UNIT_SHIFT) + H_BLANK_EXTRA;
  assign line_len = horiz_active_span + horiz_blank_part_one + horiz_blank_part_two;
  assign vert_active_span      = V_W'(cfg_vl) + V_W'(1);
  assign frame_len = vert_active_span + V_W'(cfg_vnd);
  assign fp_line  = ((vert_active_span + V_W'(vert_blank_part_one)) >= frame_len) ? V_W'(0) : vert_active_span + V_W'(vert_blank_part_one);

  // ==========================================================================
  // Pixel domain: counters and panel strobes.
  logic [H_W-1:0]   h_cnt_reg,  h_cnt_next;
  logic [V_W-1:0]   v_cnt_reg,  v_cnt_next;
  logic             line_act_reg, line_act_next;
  logic             fp_act_reg, fp_act_next;
  logic [1:0]       fp_lines_reg, fp_lines_next;
  logic             de_reg,     de_next;
  logic             lout_reg,   lout_next;
  logic             fout_reg,   fout_next;
  logic [PIX_W-1:0] data_reg,   data_next;
  logic             h_last;
  logic             v_last;

  assign h_last     = h_cnt_reg >= line_len - H_W'(1);
  assign v_last     = v_cnt_reg >= frame_len - V_W'(1);
  assign frame_wrap = h_last && v_last;
  assign pixel_take = de_next;
  // The panel samples on the falling edge, half a pixel after data change.
  assign shift_clock_out       = pix_clk;
  assign line_pulse_out        = lout_reg;
  assign frame_pulse_out       = fout_reg;
  assign display_enable_strobe = de_reg;
  assign panel_pixel_bus       = data_reg;

  always_comb begin
    h_cnt_next    = h_last ? H_W'(0) : h_cnt_reg + H_W'(1);
    v_cnt_next    = v_cnt_reg;
    if (h_last) begin
      v_cnt_next = v_last ? V_W'(0) : v_cnt_reg + V_W'(1);
    end
    line_act_next = h_cnt_reg < LINE_PULSE_CLKS;
    fp_act_next   = fp_act_reg;
    fp_lines_next = fp_lines_reg;
    // Starting eighteen clocks into the line before, two lines long.
    if (h_cnt_reg == FRAME_LEAD_CLKS) begin
      if (fp_act_reg) begin
        fp_lines_next = fp_lines_reg + 2'h1;
        if (fp_lines_reg + 2'h1 == FRAME_PULSE_LINES) begin
          fp_act_next   = 1'b0;
          fp_lines_next = 2'h0;
        end
      end else if (v_cnt_reg == fp_line) begin
        fp_act_next = 1'b1;
      end
    end
    // Enable may only start at the span's first clock, so a panel switched on
    // in mid-line never shows a short strobe.
    de_next   = panel_on && (v_cnt_reg < vert_active_span)
                && (de_reg || h_cnt_reg == horiz_blank_part_two)
                && (h_cnt_reg < horiz_blank_part_two + horiz_active_span);
    vb_next   = v_cnt_reg >= vert_active_span;
    lout_next = panel_on ? (line_act_next ^ ~lpol) : 1'b1;
    fout_next = panel_on ? (fp_act_next ^ ~fpol) : 1'b1;
    data_next = (panel_on && de_next) ? pixel_data_in : {PIX_W{1'b0}};
  end

  always_ff @(posedge pix_clk) begin
    if (!pix_rst_n) begin
      h_cnt_reg    <= {H_W{1'b0}};
      v_cnt_reg    <= {V_W{1'b0}};
      line_act_reg <= 1'b0;
      fp_act_reg   <= 1'b0;
      fp_lines_reg <= 2'h0;
      de_reg       <= 1'b0;
      vb_reg       <= 1'b0;
      lout_reg     <= 1'b1;
      fout_reg     <= 1'b1;
      data_reg     <= {PIX_W{1'b0}};
    end else begin
      h_cnt_reg    <= h_cnt_next;
      v_cnt_reg    <= v_cnt_next;
      line_act_reg <= line_act_next;
      fp_act_reg   <= fp_act_next;
      fp_lines_reg <= fp_lines_next;
      de_reg       <= panel_on && de_next;
      vb_reg       <= vb_next;
      lout_reg     <= lout_next;
      fout_reg     <= fout_next;
      data_reg     <= data_next;
    end
  end

  // ==========================================================================
  // Checks on the generated timing.
  logic [H_W-1:0] de_len_reg;
  logic [11:0]    fp_len_reg;
  logic [3:0]     lp_len_reg;
  logic           fp_cfg_ok_reg;

  always_ff @(posedge pix_clk) begin
    de_len_reg <= de_reg ? de_len_reg + H_W'(1) : H_W'(0);
    fp_len_reg <= fp_act_reg ? fp_len_reg + 12'h001 : 12'h000;
    lp_len_reg <= line_act_reg ? lp_len_reg + 4'h1 : 4'h0;
    // A pulse that spans a timing change has no single line length to match.
    fp_cfg_ok_reg <= fp_act_reg ? fp_cfg_ok_reg && (cfg_next == cfg_reg) : 1'b1;
  end

  line_width_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    $fell(line_act_reg) |-> lp_len_reg == 4'h9)
    else $error("line pulse width is not nine pixel clocks");

  enable_span_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    $fell(de_reg) |-> de_len_reg == horiz_active_span)
    else $error("display enable width differs from active span");

  line_length_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    (h_cnt_reg == line_len - H_W'(1)) |=> h_cnt_reg == H_W'(0))
    else $error("line counter did not wrap at line length");

  enable_fall_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    $fell(de_reg) && panel_on |-> $past(h_cnt_reg) == line_len - horiz_blank_part_one)
    else $error("enable fell at the wrong distance before the line pulse");

  enable_rise_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    $rose(de_reg) |-> $past(h_cnt_reg) == horiz_blank_part_two)
    else $error("enable rose at the wrong distance after the line pulse");

  frame_width_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    $fell(fp_act_reg) && fp_cfg_ok_reg |-> fp_len_reg == {line_len, 1'b0})
    else $error("frame pulse is not two lines long");

  frame_lead_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    $rose(fp_act_reg) |-> $past(h_cnt_reg) == FRAME_LEAD_CLKS
      && $past(v_cnt_reg) == $past(fp_line))
    else $error("frame pulse started at the wrong point");

  blank_lines_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    (v_cnt_reg >= vert_active_span) |=> !de_reg)
    else $error("display enable active on a blank line");

  frame_length_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    (v_cnt_reg == frame_len - V_W'(1)) && h_last |=> v_cnt_reg == V_W'(0))
    else $error("line counter did not wrap at frame length");

  line_polarity_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    panel_on && $stable(cfg_reg) |-> line_pulse_out == (line_act_reg ^ ~lpol))
    else $error("line pulse polarity does not follow its control bit");

  idle_panel_a: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
    !panel_on |=> !display_enable_strobe && line_pulse_out && frame_pulse_out)
    else $error("panel strobes active while panel mode is off");

endmodule : tptg_core

`default_nettype wire

// *** core/tptg_pkg.sv ***
/*
  Constants shared by the active-matrix panel timing generator: register
  offsets, field positions, reset values, counter widths and timing counts.
  Assumes a byte-wide register port and a pixel clock supplied from outside.
*/
// Overview of operation
// - Active line span is (width field plus one) times eight pixel clocks.
// - Line blanking totals (blank field plus four) times eight pixel clocks.
// - Blank part one lasts line-pulse start times eight plus sixteen clocks.
// - Blank part two lasts (blank field minus start) times eight plus sixteen.
// - Active frame span is the ten-bit lines field plus one line.
// - Frame blanking lasts the vertical blank field in lines.
// - Vertical blank part one lasts the frame-pulse start field in lines.
// - Vertical blank part two lasts blank field minus frame-pulse start lines.
// - Line pulse is active for nine pixel clocks once per line.
// - Frame pulse is active for exactly two line periods per frame.
// - Frame pulse leads its line pulse by one line minus eighteen clocks.
// - Enable falls blank-part-one clocks before the line pulse starts.
// - Enable rises blank-part-two clocks after the line pulse starts.
// - Shift clock runs once per pixel; data change away from its fall.
// - Panel strobes work only while the panel mode bit is set; the shift clock always runs.
// - Line polarity bit zero gives active low, one gives active high.
// - Frame polarity bit zero gives active low, one gives active high.
`default_nettype none

package tptg_pkg;

  // ==========================================================================
  // Widths.
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIX_W  = 12;
  localparam int unsigned H_W    = 11;
  localparam int unsigned V_W    = 11;
  localparam int unsigned CFG_W  = 47;

  // ==========================================================================
  // Register offsets.
  localparam logic [4:0] OFS_MODE      = 5'h01;
  localparam logic [4:0] OFS_HWIDTH    = 5'h04;
  localparam logic [4:0] OFS_VLINES_LO = 5'h05;
  localparam logic [4:0] OFS_VLINES_HI = 5'h06;
  localparam logic [4:0] OFS_LPSTART   = 5'h07;
  localparam logic [4:0] OFS_HBLANK    = 5'h08;
  localparam logic [4:0] OFS_FPSTART   = 5'h09;
  localparam logic [4:0] OFS_VBLANK    = 5'h0A;
  localparam logic [4:0] OFS_STATUS    = 5'h10;

  // ==========================================================================
  // Field positions and reset values.
  localparam int unsigned MODE_PANEL_BIT = 7;
  localparam int unsigned MODE_LPOL_BIT  = 4;
  localparam int unsigned MODE_FPOL_BIT  = 3;
  localparam int unsigned STAT_VBLANK_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT   = 1;
  localparam logic [7:0]  RST_REG        = 8'h00;
  localparam logic [CFG_W-1:0] RST_CFG   = 47'h0000_0000_0000;

  // ==========================================================================
  // Timing counts, in pixel clocks unless named in lines.
  localparam int unsigned H_UNIT_SHIFT      = 3;
  localparam logic [H_W-1:0] H_BLANK_EXTRA  = 11'h010;
  localparam logic [H_W-1:0] LINE_PULSE_CLKS = 11'h009;
  localparam logic [H_W-1:0] FRAME_LEAD_CLKS = 11'h012;
  localparam logic [1:0]     FRAME_PULSE_LINES = 2'h2;

endpackage : tptg_pkg

`default_nettype wire

// *** sim/tptg_panel_model.sv ***
/*
  Behavioural active-matrix panel input: samples the strobes and data on the
  falling shift clock edge and reports span lengths in shift clock periods.
  Assumes the bench tells it the active levels of line and frame pulse.
*/
`timescale 1ns/10ps
`default_nettype none

module tptg_panel_model (
  // Panel pins.
  input  wire logic                       shift_clock_out,
  input  wire logic                       frame_pulse_out,
  input  wire logic                       line_pulse_out,
  input  wire logic                       display_enable_strobe,
  input  wire logic [tptg_pkg::PIX_W-1:0] panel_pixel_bus,
  // Active levels.
  input  wire logic                       lpol,
  input  wire logic                       fpol,
  // Measurements.
  output var  int                         lp_period,
  output var  int                         lp_width,
  output var  int                         de_width,
  output var  int                         de_after_lp,
  output var  int                         de_before_lp,
  output var  int                         fp_width,
  output var  int                         fp_lead,
  output var  int                         fp_gap,
  output var  int                         frame_lines,
  output var  int                         frame_de_lines,
  output var  int                         data_errs
);
  import tptg_pkg::*;

  int               cyc, lp_t, fp_t, de_t, de_f, line_idx, de_line, fp_line, n_de;
  logic             lp_q, fp_q, de_q, lp_on, fp_on;
  logic [PIX_W-1:0] dat_q;

  assign lp_on = (line_pulse_out === lpol);
  assign fp_on = (frame_pulse_out === fpol);

  initial begin
    {cyc, lp_t, fp_t, de_t, de_f, line_idx, de_line, fp_line, n_de} = '0;
    {lp_period, lp_width, de_width, de_after_lp, de_before_lp, fp_width} = '0;
    {fp_lead, fp_gap, frame_lines, frame_de_lines, data_errs} = '0;
    {lp_q, fp_q, de_q} = 3'h0;
    dat_q = '0;
  end

  // The panel takes every pin on the falling shift clock edge.
  always @(negedge shift_clock_out) begin
    cyc = cyc + 1;
    if (lp_on && !lp_q) begin
      if (fp_on && fp_t > lp_t) fp_lead = cyc - fp_t;
      if (de_f > lp_t) de_before_lp = cyc - de_f;
      lp_period = cyc - lp_t;
      lp_t = cyc;
      line_idx++;
    end
    if (!lp_on && lp_q) lp_width = cyc - lp_t;
    if (fp_on && !fp_q) begin
      fp_t = cyc;
      fp_gap = line_idx - de_line;
      frame_lines = line_idx - fp_line;
      fp_line = line_idx;
      frame_de_lines = n_de;
      n_de = 0;
    end
    if (!fp_on && fp_q) fp_width = cyc - fp_t;
    if (display_enable_strobe === 1'b1 && !de_q) begin
      de_t = cyc;
      de_after_lp = cyc - lp_t;
      de_line = line_idx;
      n_de++;
    end
    if (display_enable_strobe === 1'b0 && de_q) begin
      de_width = cyc - de_t;
      de_f = cyc;
    end
    if (display_enable_strobe === 1'b1 && de_q && panel_pixel_bus !== dat_q + 12'h001) data_errs++;
    if (display_enable_strobe === 1'b0 && panel_pixel_bus !== '0) data_errs++;
    lp_q = lp_on;
    fp_q = fp_on;
    de_q = (display_enable_strobe === 1'b1);
    dat_q = panel_pixel_bus;
  end
endmodule : tptg_panel_model

`default_nettype wire

// *** sim/tb.sv ***
/*
  Self-checking bench for the panel timing generator: random configurations,
  span checks against a bench model, register and reset checks.
  Assumes tptg_pkg, tptg_core and the panel model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  import tptg_pkg::*;

  // ==========================================================================
  // Signals.
  logic              clk_sys, rstn, pix_clk, reg_wr, reg_rd, pixel_take, lpol, fpol;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
  logic [PIX_W-1:0]  pixel_data_in, pix_o;
  logic              fp_o, lp_o, sc_o, de_o;
  int lp_period, lp_width, de_width, de_after_lp, de_before_lp, fp_width, fp_lead;
  int fp_gap, frame_lines, frame_de_lines, data_errs;
  int mismatches, n_compared, seed, w, hb, lps, lines, vb, fps, line_len, frame_len;

  tptg_core u_tptg_core (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pix_clk(pix_clk), .pixel_data_in(pixel_data_in), .pixel_take(pixel_take),
    .frame_pulse_out(fp_o), .line_pulse_out(lp_o), .shift_clock_out(sc_o),
    .display_enable_strobe(de_o), .panel_pixel_bus(pix_o));

  tptg_panel_model u_tptg_panel_model (.shift_clock_out(sc_o), .frame_pulse_out(fp_o),
    .line_pulse_out(lp_o), .display_enable_strobe(de_o), .panel_pixel_bus(pix_o),
    .lpol(lpol), .fpol(fpol), .lp_period(lp_period), .lp_width(lp_width),
    .de_width(de_width), .de_after_lp(de_after_lp), .de_before_lp(de_before_lp),
    .fp_width(fp_width), .fp_lead(fp_lead), .fp_gap(fp_gap), .frame_lines(frame_lines),
    .frame_de_lines(frame_de_lines), .data_errs(data_errs));

  // ==========================================================================
  // Clocks and pixel source.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    pix_clk = 1'b0;
    #7.3;
    forever #62.5 pix_clk = ~pix_clk;
  end

  // Counting source words lets the panel see a lost or repeated pixel inside an enable span.
  always @(posedge pix_clk) begin
    if (pixel_take === 1'b1) pixel_data_in <= pixel_data_in + 12'h001;
  end

  // ==========================================================================
  // Tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd_reg

  // Pins must sit at their inactive levels with the shift clock following.
  task automatic idle_check(input string what);
    int bad;
    bad = 0;
    repeat (200) begin
      @(negedge pix_clk);
      #1;
      if (lp_o !== 1'b1 || fp_o !== 1'b1 || de_o !== 1'b0 || pix_o !== '0) bad++;
      if (sc_o !== pix_clk) bad++;
    end
    chk(bad, 0, what);
  endtask : idle_check

  task automatic do_reset;
    logic [4:0] ofs [9];
    ofs = '{OFS_MODE, OFS_HWIDTH, OFS_VLINES_LO, OFS_VLINES_HI, OFS_LPSTART,
            OFS_HBLANK, OFS_FPSTART, OFS_VBLANK, 5'h1F};
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    repeat (4) @(posedge pix_clk);
    chk(reg_rdata, 0, "rdata in reset");
    @(posedge clk_sys);
    rstn <= 1'b1;
    idle_check("idle after reset");
    foreach (ofs[i]) begin
      rd_reg(ofs[i], rd_val);
      chk(rd_val, 0, "register after reset");
    end
  endtask : do_reset

  task automatic run_cfg;
    int k;
    logic [7:0] mode;
    mode  = {1'b1, 7'($random(seed))};
    w     = {$random(seed)} % 2;
    hb    = {$random(seed)} % 6;
    lps   = {$random(seed)} % (hb + 1);
    lines = 1 + {$random(seed)} % 3;
    vb    = 2 + {$random(seed)} % 3;
    fps   = {$random(seed)} % (vb - 1);
    wr_reg(OFS_MODE, mode);
    wr_reg(OFS_HWIDTH, 8'(w));
    wr_reg(OFS_VLINES_LO, 8'(lines));
    wr_reg(OFS_VLINES_HI, 8'h00);
    wr_reg(OFS_LPSTART, 8'(lps));
    wr_reg(OFS_HBLANK, 8'(hb));
    wr_reg(OFS_FPSTART, 8'(fps));
    wr_reg(OFS_VBLANK, 8'(vb));
    lpol <= mode[MODE_LPOL_BIT];
    fpol <= mode[MODE_FPOL_BIT];
    rd_reg(OFS_MODE, rd_val);
    chk(rd_val, mode, "mode readback");
    rd_reg(OFS_HBLANK, rd_val);
    chk(rd_val, hb, "blank readback");
    k = 0;
    do begin
      rd_reg(OFS_STATUS, rd_val);
      k++;
    end while (rd_val[STAT_BUSY_BIT] !== 1'b0 && k < 100);
    chk(k < 100, 1, "config busy clears");
    line_len  = (w + 1) * 8 + (hb + 4) * 8;
    frame_len = lines + 1 + vb;
    repeat (4 * frame_len * line_len) @(posedge pix_clk);
    chk(lp_period, line_len, "line period");
    chk(de_width, (w + 1) * 8, "enable width");
    chk(de_before_lp, lps * 8 + 16, "blank part one");
    chk(de_after_lp, (hb - lps) * 8 + 16, "blank part two");
    chk(frame_de_lines, lines + 1, "display lines");
    chk(frame_lines, frame_len, "frame lines");
    chk(fp_gap, fps + 1, "frame pulse line");
    chk(lp_width, 9, "line pulse width");
    chk(fp_width, 2 * line_len, "frame pulse width");
    chk(fp_lead, line_len - 18, "frame pulse lead");
    chk(data_errs, 0, "pixel data");
    $display("test config w=%0d hb=%0d lps=%0d done", w, hb, lps);
  endtask : run_cfg

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Main sequence and watchdog.
  initial begin
    {rstn, reg_wr, reg_rd, lpol, fpol} = 5'h00;
    reg_addr      = '0;
    reg_wdata     = '0;
    pixel_data_in = '0;
    mismatches    = 0;
    n_compared    = 0;
    seed          = 32'hc85a;
    do_reset();
    $display("test reset done");
    run_cfg();
    do_reset();
    $display("test second reset done");
    run_cfg();
    run_cfg();
    lpol <= 1'b0;
    fpol <= 1'b0;
    wr_reg(OFS_MODE, 8'h00);
    repeat (2 * frame_len * line_len) @(posedge pix_clk);
    idle_check("panel mode off");
    $display("test mode off done");
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
